// ==== lut_host_master.sv ====
`timescale 1ns/1ns
`default_nettype none
module lut_host_master
  import lut_ports_pkg::*;
(
  input  wire logic        i_ref_clk,
  input  wire logic [15:0] i_rdata,
  output var  logic        o_wr,
  output var  logic        o_rd,
  output var  logic [2:0]  o_sel,
  output var  logic [15:0] o_wdata,
  output var  logic        o_fc_mode,
  output var  logic        o_bx_reset
);
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_sel = 3'h6;
    o_wdata = 16'h0000;
    o_fc_mode = 1'b0;
    o_bx_reset = 1'b0;
  end
  // Control is taken by raising fast-control mode, then pulsing bunch-crossing reset for one cycle.
  task automatic control(input logic m);
    @(negedge i_ref_clk);
    o_fc_mode = m;
    if (m) begin
      @(negedge i_ref_clk);
      o_bx_reset = 1'b1;
      @(negedge i_ref_clk);
      o_bx_reset = 1'b0;
    end
  endtask
  // Data is inverted on release so a stale word never passes as valid.
  task automatic xfer(input logic w, input logic [2:0] s, input logic [15:0] d,
                      output logic [15:0] q);
    @(negedge i_ref_clk);
    o_wr = w;
    o_rd = !w;
    o_sel = s;
    o_wdata = d;
    @(negedge i_ref_clk);
    q = i_rdata;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// ==== lut_parameter_access_ports.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "lut_ports_params.svh"

// Behaviour
// RL1: Drift-tube phi word is 12 bits; upper four bits read zero.
// RL2: Eta file holds 26 words: 8 min, 8 max, 6 windows, 4 offsets.
// RL3: Eta port accesses the eta file word chosen by the eta index counter.
// RL4: Eta minimum resets to 22,22,14,14,14,10,10,10.
// RL5: Eta maximum resets to 127 for five types, 24 for last three.
// RL6: Eta windows reset to 2, offsets to 0.
// RL7: Eta parameter sits in bits 7:0; upper bits ignored, read zero.
// RL8: Min, max and offset accept 0..127; windows accept 0..255.
// RL9: Each unit accepts a pair only if both etas lie within its limits; units 7 and 8 check only their station 2 eta.
// RL10: First six units also cut on eta difference using their window.
// RL11: Each station's offset is added to its eta before the cuts.
// RL12: Table ports work only in host fast-control mode with trigger stopped.
// RL13: Host writes 0x0100 to config, then 0x00C8 to action first.
// RL14: Action 0x00C8 issues bunch-crossing reset, stopping the trigger machine.
// RL15: Global eta port uses the shared global counter, then increments it.
// RL16: Global eta word: eta bits 6:0, phi bend bits 11:7, upper zero.
// RL17: Global phi port uses the shared global counter, then increments it.
// RL18: Global phi word is 12 bits; bits 15:12 read zero.
// RL19: Local phi port uses its own counter, incremented after each transfer.
// RL20: Local phi word: phi bits 9:0, bend bits 15:10.
// RL21: Momentum port uses the momentum counter, incremented after each access.
// RL22: Momentum word packs trailing and leading charge, quality and rank.
// RL23: Validation register stores and returns 16 bits with no side effect.
// RL24: Refused protected writes leave tables and counters unchanged.
module lut_parameter_access_ports
  import lut_ports_pkg::*;
(
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_nrst,
  input  wire logic                     i_wr,
  input  wire logic                     i_rd,
  input  wire logic [2:0]               i_sel,
  input  wire logic [15:0]              i_wdata,
  input  wire logic                     i_host_fc_mode,
  input  wire logic                     i_bx_reset,
  input  wire logic                     i_trigger_run,
  input  wire logic [4:0]               i_eta_index_load,
  input  wire logic                     i_eta_index_we,
  input  wire logic [`GLOBAL_AW-1:0]    i_global_addr_load,
  input  wire logic                     i_global_addr_we,
  input  wire logic [`LOCAL_AW-1:0]     i_local_addr_load,
  input  wire logic                     i_local_addr_we,
  input  wire logic [`MOMENTUM_AW-1:0]  i_momentum_addr_load,
  input  wire logic                     i_momentum_addr_we,
  input  wire logic [27:0]              i_station_eta,
  input  wire logic [7:0]               i_pair_valid,
  output logic [15:0]                   o_rdata,
  output logic                          o_access_ok,
  output logic                          o_trigger_stopped_state,
  output logic [4:0]                    o_eta_index_counter,
  output logic [`GLOBAL_AW-1:0]         o_global_table_addr,
  output logic [`LOCAL_AW-1:0]          o_local_table_addr,
  output logic [`MOMENTUM_AW-1:0]       o_momentum_addr,
  output logic [7:0]                    o_unit_accept
);

  // ****************************************************************
  // Trigger state and access gate
  // ****************************************************************
  trig_state_type state_q;
  host_req_type   req;
  logic           granted;
  logic           prot_wr;
  logic           prot_rd;
  station_eta_type st_in;

  assign req     = '{wr: i_wr, rd: i_rd, sel: i_sel, wdata: i_wdata};
  assign st_in   = station_eta_type'(i_station_eta);

  // The bunch-crossing reset stops the machine; only a run command restarts it.
  // The held state is never entered on purpose; it falls back to stopped so a
  // corrupted state register cannot leave the tables locked against the host.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_q <= S_STOPPED;
    end else begin
      case (state_q)
        S_RUN:     if (i_bx_reset) state_q <= S_STOPPED;  // see RL14
        S_STOPPED: if (i_trigger_run && !i_bx_reset) state_q <= S_RUN;
        S_HELD:    state_q <= S_STOPPED;
        default:   state_q <= S_STOPPED;
      endcase
    end
  end

  assign granted = i_host_fc_mode && (state_q == S_STOPPED);  // see RL12 see RL13
  assign prot_wr = req.wr && granted && (req.sel != `SEL_VALIDATION);  // see RL24
  assign prot_rd = req.rd && granted && (req.sel != `SEL_VALIDATION);
  assign o_access_ok = granted;
  assign o_trigger_stopped_state = (state_q == S_STOPPED);

  // ****************************************************************
  // Address counters
  // ****************************************************************
  logic [4:0]               eta_idx_q;
  logic [`GLOBAL_AW-1:0]    gaddr_q;
  logic [`LOCAL_AW-1:0]     laddr_q;
  logic [`MOMENTUM_AW-1:0]  paddr_q;
  logic                     g_hit;

  assign g_hit = (req.sel == `SEL_DT_PHI) || (req.sel == `SEL_GLOBAL_ETA) ||
                 (req.sel == `SEL_GLOBAL_AZ);

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      eta_idx_q <= 5'h00;
    end else if (i_eta_index_we) begin
      eta_idx_q <= i_eta_index_load;
    end
  end

  // Shared by drift-tube, global eta and global phi tables.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      gaddr_q <= '0;
    end else if (i_global_addr_we) begin
      gaddr_q <= i_global_addr_load;
    end else if ((prot_wr || prot_rd) && g_hit) begin
      gaddr_q <= gaddr_q + 1'b1;  // see RL15 see RL17
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      laddr_q <= '0;
    end else if (i_local_addr_we) begin
      laddr_q <= i_local_addr_load;
    end else if ((prot_wr || prot_rd) && req.sel == `SEL_LOCAL_AZ) begin
      laddr_q <= laddr_q + 1'b1;  // see RL19
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      paddr_q <= '0;
    end else if (i_momentum_addr_we) begin
      paddr_q <= i_momentum_addr_load;
    end else if ((prot_wr || prot_rd) && req.sel == `SEL_MOMENTUM) begin
      paddr_q <= paddr_q + 1'b1;  // see RL21
    end
  end

  assign o_eta_index_counter = eta_idx_q;
  assign o_global_table_addr = gaddr_q;
  assign o_local_table_addr  = laddr_q;
  assign o_momentum_addr     = paddr_q;

  // ****************************************************************
  // Lookup tables
  // ****************************************************************
  logic [11:0] dt_mem [0:(1<<`GLOBAL_AW)-1];
  logic [11:0] ge_mem [0:(1<<`GLOBAL_AW)-1];
  logic [11:0] gp_mem [0:(1<<`GLOBAL_AW)-1];
  logic [15:0] lp_mem [0:(1<<`LOCAL_AW)-1];
  logic [15:0] pt_mem [0:(1<<`MOMENTUM_AW)-1];
  logic [15:0] scratch_q;

  // Table storage carries no reset: contents are loaded by the host.
  // A table read before it is loaded returns unknown data.
  always_ff @(posedge i_ref_clk) begin
    if (prot_wr && req.sel == `SEL_DT_PHI) begin
      dt_mem[gaddr_q] <= req.wdata[11:0];  // see RL1
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (prot_wr && req.sel == `SEL_GLOBAL_ETA) begin
      ge_mem[gaddr_q] <= req.wdata[11:0];  // see RL16
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (prot_wr && req.sel == `SEL_GLOBAL_AZ) begin
      gp_mem[gaddr_q] <= req.wdata[11:0];  // see RL18
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (prot_wr && req.sel == `SEL_LOCAL_AZ) begin
      lp_mem[laddr_q] <= req.wdata;  // see RL20
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (prot_wr && req.sel == `SEL_MOMENTUM) begin
      pt_mem[paddr_q] <= req.wdata;  // see RL22
    end
  end

  // The scratch word is open at all times so a stuck bus can be diagnosed.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      scratch_q <= 16'h0000;
    end else if (req.wr && req.sel == `SEL_VALIDATION) begin
      scratch_q <= req.wdata;  // see RL23
    end
  end

  // ****************************************************************
  // Eta parameter file
  // ****************************************************************
  logic [7:0] eta_q [0:`ETA_WORDS-1];

  genvar gi;
  generate
    for (gi = 0; gi < `ETA_WORDS; gi++) begin : g_eta
      localparam logic [7:0] RST =
        (gi < `ETA_MIN_BASE + 2) ? `ETA_MIN_R0 :
        (gi < `ETA_MIN_BASE + 5) ? `ETA_MIN_R2 :
        (gi < `ETA_MAX_BASE)     ? `ETA_MIN_R5 :
        (gi < `ETA_MAX_BASE + 5) ? `ETA_MAX_R0 :
        (gi < `ETA_WIN_BASE)     ? `ETA_MAX_R5 :
        (gi < `ETA_OFS_BASE)     ? `ETA_WIN_R  : `ETA_OFS_R;  // see RL2 see RL4 see RL5 see RL6
      localparam logic IS_WIN = (gi >= `ETA_WIN_BASE) && (gi < `ETA_OFS_BASE);
      always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          eta_q[gi] <= RST;
        end else if (prot_wr && req.sel == `SEL_ETA_PARAM && eta_idx_q == 5'(gi)) begin
          // Windows take the full byte; other words drop bit 7.
          eta_q[gi] <= IS_WIN ? req.wdata[7:0]
                              : (req.wdata[7:0] & `ETA_LIMIT_MAX);  // see RL3 see RL7 see RL8
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Eta cuts of the extrapolation units
  // ****************************************************************
  logic [6:0] st_eta [0:3];
  logic [6:0] raw_eta [0:3];

  assign raw_eta[0] = st_in.st1;
  assign raw_eta[1] = st_in.st2;
  assign raw_eta[2] = st_in.st3;
  assign raw_eta[3] = st_in.st4;

  // The offset sum wraps at seven bits, so a large offset folds a high eta
  // into the low range; offsets are meant to stay small corrections.
  generate
    for (gi = 0; gi < `ETA_STATIONS; gi++) begin : g_ofs
      assign st_eta[gi] = 7'(raw_eta[gi] + eta_q[`ETA_OFS_BASE + gi][6:0]);  // see RL11
    end
  endgenerate

  // Station pairs per unit; units 7 and 8 use station 2 against a barrel
  // segment, whose eta is not delivered, so only the endcap side is cut.
  localparam int SA [0:7] = '{0, 0, 1, 1, 2, 0, 1, 1};
  localparam int SB [0:7] = '{1, 2, 2, 3, 3, 1, 1, 1};

  generate
    for (gi = 0; gi < `ETA_UNITS; gi++) begin : g_unit
      logic [6:0] ea;
      logic [6:0] eb;
      logic [7:0] lo;
      logic [7:0] hi;
      logic       in_a;
      logic       in_b;
      logic [6:0] diff;
      logic       win_ok;
      assign ea   = st_eta[SA[gi]];
      assign eb   = st_eta[SB[gi]];
      assign lo   = eta_q[`ETA_MIN_BASE + gi];
      assign hi   = eta_q[`ETA_MAX_BASE + gi];
      assign in_a = ({1'b0, ea} >= lo) && ({1'b0, ea} <= hi);
      assign in_b = (gi >= `ETA_WIN_UNITS) ? 1'b1 :
                    (({1'b0, eb} >= lo) && ({1'b0, eb} <= hi));  // see RL9
      assign diff = (ea > eb) ? 7'(ea - eb) : 7'(eb - ea);
      if (gi < `ETA_WIN_UNITS) begin : g_win
        assign win_ok = ({1'b0, diff} <= eta_q[`ETA_WIN_BASE + gi]);  // see RL10
      end else begin : g_nowin
        assign win_ok = 1'b1;
      end
      always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
          o_unit_accept[gi] <= 1'b0;
        end else begin
          o_unit_accept[gi] <= i_pair_valid[gi] && in_a && in_b && win_ok;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Read data
  // ****************************************************************
  // Refused reads return zero rather than stale table data.
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_rdata <= 16'h0000;
    end else if (req.rd) begin
      case (req.sel)
        `SEL_DT_PHI:     o_rdata <= prot_rd ? {4'h0, dt_mem[gaddr_q]} : 16'h0000;  // see RL1
        `SEL_ETA_PARAM:  o_rdata <= (prot_rd && eta_idx_q < 5'(`ETA_WORDS)) ?
                                    {8'h00, eta_q[eta_idx_q]} : 16'h0000;  // see RL3 see RL7
        `SEL_GLOBAL_ETA: o_rdata <= prot_rd ? {4'h0, ge_mem[gaddr_q]} : 16'h0000;  // see RL16
        `SEL_GLOBAL_AZ:  o_rdata <= prot_rd ? {4'h0, gp_mem[gaddr_q]} : 16'h0000;  // see RL18
        `SEL_LOCAL_AZ:   o_rdata <= prot_rd ? lp_mem[laddr_q] : 16'h0000;
        `SEL_MOMENTUM:   o_rdata <= prot_rd ? pt_mem[paddr_q] : 16'h0000;
        `SEL_VALIDATION: o_rdata <= scratch_q;  // see RL23
        default:         o_rdata <= 16'h0000;
      endcase
    end
  end

endmodule
`default_nettype wire

// ==== lut_parameter_access_ports_properties.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "lut_ports_params.svh"
module lut_port_checker
  import lut_ports_pkg::*;
(
  input wire logic                    i_ref_clk,
  input wire logic                    i_nrst,
  input wire logic                    i_wr,
  input wire logic                    i_rd,
  input wire logic [2:0]              i_sel,
  input wire logic                    i_bx_reset,
  input wire logic                    i_global_addr_we,
  input wire logic                    i_local_addr_we,
  input wire logic                    i_momentum_addr_we,
  input wire logic [15:0]             o_rdata,
  input wire logic                    o_access_ok,
  input wire logic                    o_trigger_stopped_state,
  input wire logic [`GLOBAL_AW-1:0]   o_global_table_addr,
  input wire logic [`LOCAL_AW-1:0]    o_local_table_addr,
  input wire logic [`MOMENTUM_AW-1:0] o_momentum_addr
);
  logic go;
  logic prot;
  logic no_ld;
  assign go = (i_wr || i_rd) && o_access_ok;
  assign prot = (i_sel != `SEL_VALIDATION);
  assign no_ld = !(i_global_addr_we || i_local_addr_we || i_momentum_addr_we);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);
  property p_bx_stop;
    i_bx_reset |=> o_trigger_stopped_state;
  endproperty
  a_bx_stop: assert property (p_bx_stop) else $error("not stopped after bx");
  property p_glob_inc;
    go && i_sel inside {3'h0, 3'h2, 3'h3} && no_ld
      |=> o_global_table_addr == $past(o_global_table_addr) + 1'b1;
  endproperty
  a_glob_inc: assert property (p_glob_inc) else $error("global addr");
  property p_loc_inc;
    go && i_sel == 3'h4 && no_ld |=> o_local_table_addr == $past(o_local_table_addr) + 1'b1;
  endproperty
  a_loc_inc: assert property (p_loc_inc) else $error("local addr");
  property p_mom_inc;
    go && i_sel == 3'h5 && no_ld |=> o_momentum_addr == $past(o_momentum_addr) + 1'b1;
  endproperty
  a_mom_inc: assert property (p_mom_inc) else $error("momentum addr");
  property p_refused;
    (i_wr || i_rd) && prot && !o_access_ok && no_ld |=> $stable(o_global_table_addr)
      && $stable(o_local_table_addr) && $stable(o_momentum_addr);
  endproperty
  a_refused: assert property (p_refused) else $error("counter moved");
  property p_rd_refused;
    i_rd && prot && !o_access_ok |=> o_rdata == 16'h0000;
  endproperty
  a_rd_refused: assert property (p_rd_refused) else $error("refused read data");
  property p_top_zero;
    i_rd && i_sel inside {3'h0, 3'h2, 3'h3} |=> o_rdata[15:12] == 4'h0;
  endproperty
  a_top_zero: assert property (p_top_zero) else $error("upper bits");
  property p_eta_top;
    i_rd && i_sel == `SEL_ETA_PARAM |=> o_rdata[15:8] == 8'h00;
  endproperty
  a_eta_top: assert property (p_eta_top) else $error("eta upper bits");
endmodule
bind lut_parameter_access_ports lut_port_checker chk_u (
  .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_wr(i_wr), .i_rd(i_rd), .i_sel(i_sel),
  .i_bx_reset(i_bx_reset), .i_global_addr_we(i_global_addr_we),
  .i_local_addr_we(i_local_addr_we), .i_momentum_addr_we(i_momentum_addr_we),
  .o_rdata(o_rdata), .o_access_ok(o_access_ok),
  .o_trigger_stopped_state(o_trigger_stopped_state),
  .o_global_table_addr(o_global_table_addr), .o_local_table_addr(o_local_table_addr),
  .o_momentum_addr(o_momentum_addr));
`default_nettype wire

// ==== lut_parameter_access_ports_tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "lut_ports_params.svh"
module lut_parameter_access_ports_tb_top
  import lut_ports_pkg::*;
;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        run = 1'b0;
  logic        ewe = 1'b0;
  logic        gwe = 1'b0;
  logic        lwe = 1'b0;
  logic        mwe = 1'b0;
  logic [4:0]  eidx = 5'h00;
  logic [3:0]  ald = 4'h0;
  logic [27:0] st = 28'h0000000;
  logic [7:0]  pv = 8'h00;
  logic        wr, rd, fc, bx, ok, stp;
  logic [2:0]  sel;
  logic [15:0] wd, rdat, q, d;
  logic [3:0]  ga, la, ma;
  logic [4:0]  ecnt;
  logic [7:0]  acc;
  logic [15:0] mem [8][16];
  logic [2:0]  tsel [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5};
  int          seed, k, a, p, mismatches = 0, n_compared = 0;

  lut_host_master host_u (.i_ref_clk(clk), .i_rdata(rdat), .o_wr(wr), .o_rd(rd),
    .o_sel(sel), .o_wdata(wd), .o_fc_mode(fc), .o_bx_reset(bx));
  lut_parameter_access_ports dut_u (.i_ref_clk(clk), .i_nrst(nrst), .i_wr(wr),
    .i_rd(rd), .i_sel(sel), .i_wdata(wd), .i_host_fc_mode(fc), .i_bx_reset(bx),
    .i_trigger_run(run), .i_eta_index_load(eidx), .i_eta_index_we(ewe),
    .i_global_addr_load(ald), .i_global_addr_we(gwe), .i_local_addr_load(ald),
    .i_local_addr_we(lwe), .i_momentum_addr_load(ald), .i_momentum_addr_we(mwe),
    .i_station_eta(st), .i_pair_valid(pv), .o_rdata(rdat), .o_access_ok(ok),
    .o_trigger_stopped_state(stp), .o_eta_index_counter(ecnt),
    .o_global_table_addr(ga), .o_local_table_addr(la), .o_momentum_addr(ma),
    .o_unit_accept(acc));

  always #4 clk = ~clk;

  task automatic cmp(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic load(input logic [2:0] s, input int v);
    @(negedge clk);
    eidx = 5'(v);
    ald = 4'(v);
    ewe = (s == 3'h1);
    gwe = (s <= 3'h3) && (s != 3'h1);
    lwe = (s == 3'h4);
    mwe = (s == 3'h5);
    @(negedge clk);
    {ewe, gwe, lwe, mwe} = 4'h0;
  endtask
  function automatic logic [15:0] eta_def(input int i);
    return {8'h00, (i < 2) ? 8'h16 : (i < 5) ? 8'h0e : (i < 8) ? 8'h0a :
      (i < 13) ? 8'h7f : (i < 16) ? 8'h18 : (i < 22) ? 8'h02 : 8'h00};
  endfunction
  // Only window words keep bit 7; indices past the file read as zero.
  function automatic logic [15:0] eta_exp(input int i, input logic [15:0] v);
    if (i >= 26) return 16'h0000;
    return (i >= 16 && i < 22) ? {8'h00, v[7:0]} : {9'h000, v[6:0]};
  endfunction

  initial begin
    #100000;
    mismatches++;
    end_of_test();
  end

  initial begin
    seed = 45853;
    repeat (5) @(posedge clk);
    @(negedge clk);
    nrst = 1'b1;
    host_u.control(1'b1);
    cmp("grant", {15'h0000, ok}, 16'h0001);
    for (k = 0; k < 26; k++) begin
      load(3'h1, k);
      cmp("eta_index", {11'h000, ecnt}, 16'(k));
      host_u.xfer(1'b0, `SEL_ETA_PARAM, 16'h0000, q);
      cmp("eta_default", q, eta_def(k));
    end
    st = {4{7'h1e}};
    pv = 8'hff;
    repeat (3) @(negedge clk);
    cmp("accept", {8'h00, acc}, 16'h001f);
    load(3'h1, 22);
    host_u.xfer(1'b1, `SEL_ETA_PARAM, 16'h000a, q);
    repeat (3) @(negedge clk);
    cmp("accept_ofs", {8'h00, acc}, 16'h001c);
    for (k = 0; k < 27; k++) begin
      d = (k == 8) ? 16'hffff : 16'($random(seed));
      load(3'h1, k);
      host_u.xfer(1'b1, `SEL_ETA_PARAM, d, q);
      load(3'h1, k);
      host_u.xfer(1'b0, `SEL_ETA_PARAM, d, q);
      cmp("eta_rw", q, eta_exp(k, d));
    end
    for (k = 0; k < 5; k++) begin
      for (p = 0; p < 2; p++) begin
        load(tsel[k], 0);
        for (a = 0; a < 16; a++) begin
          if (p == 0) mem[tsel[k]][a] = (a == 0) ? 16'hffff : 16'($random(seed));
          d = mem[tsel[k]][a] & ((tsel[k] <= 3'h3) ? 16'h0fff : 16'hffff);
          host_u.xfer(p == 0, tsel[k], mem[tsel[k]][a], q);
          if (p == 1) cmp("table", q, d);
          cmp("addr", {12'h000, (tsel[k] == 3'h4) ? la : (tsel[k] == 3'h5) ? ma : ga},
            16'(a + 1) & 16'h000f);
        end
      end
    end
    host_u.control(1'b0);
    load(3'h2, 3);
    cmp("refused_grant", {15'h0000, ok}, 16'h0000);
    host_u.xfer(1'b1, 3'h2, 16'h0555, q);
    host_u.xfer(1'b0, 3'h2, 16'h0000, q);
    cmp("refused_read", q, 16'h0000);
    cmp("refused_addr", {12'h000, ga}, 16'h0003);
    d = 16'($random(seed));
    host_u.xfer(1'b1, 3'h6, d, q);
    host_u.xfer(1'b0, 3'h6, 16'h0000, q);
    cmp("validation", q, d);
    host_u.control(1'b1);
    @(negedge clk);
    run = 1'b1;
    @(negedge clk);
    run = 1'b0;
    host_u.xfer(1'b0, 3'h2, 16'h0000, q);
    cmp("running_read", q, 16'h0000);
    host_u.control(1'b1);
    cmp("stopped", {15'h0000, stp}, 16'h0001);
    host_u.xfer(1'b0, 3'h2, 16'h0000, q);
    cmp("kept_word", q, mem[2][3] & 16'h0fff);
    // A reset with the trigger stopped again must restore the eta file and leave the gate open.
    @(negedge clk);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    cmp("reset_grant", {15'h0000, ok}, 16'h0001);
    nrst = 1'b1;
    st = {7'h0c, 7'h14, 7'h10, 7'h10};
    pv = 8'h7f;
    repeat (3) @(negedge clk);
    cmp("accept_cuts", {8'h00, acc}, 16'h0050);
    load(3'h1, 16);
    host_u.xfer(1'b0, `SEL_ETA_PARAM, 16'h0000, q);
    cmp("eta_reset", q, 16'h0002);
    end_of_test();
  end
endmodule
`default_nettype wire

// ==== lut_ports_params.svh ====
`ifndef LUT_PORTS_PARAMS_SVH
`define LUT_PORTS_PARAMS_SVH

// Port selector codes on the internal register port.
`define SEL_DT_PHI        3'h0
`define SEL_ETA_PARAM     3'h1
`define SEL_GLOBAL_ETA    3'h2
`define SEL_GLOBAL_AZ     3'h3
`define SEL_LOCAL_AZ      3'h4
`define SEL_MOMENTUM      3'h5
`define SEL_VALIDATION    3'h6

// Table address widths (depth = 2**width).
`define GLOBAL_AW         4
`define LOCAL_AW          4
`define MOMENTUM_AW       4

// Eta parameter file layout.
`define ETA_WORDS         26
`define ETA_MIN_BASE      0
`define ETA_MAX_BASE      8
`define ETA_WIN_BASE      16
`define ETA_OFS_BASE      22
`define ETA_UNITS         8
`define ETA_WIN_UNITS     6
`define ETA_STATIONS      4
`define ETA_LIMIT_MAX     8'h7f

// Eta parameter reset values.
`define ETA_MIN_R0        8'h16
`define ETA_MIN_R2        8'h0e
`define ETA_MIN_R5        8'h0a
`define ETA_MAX_R0        8'h7f
`define ETA_MAX_R5        8'h18
`define ETA_WIN_R         8'h02
`define ETA_OFS_R         8'h00

// Field masks of the table words.
`define MASK_12           16'h0fff
`define MASK_8            16'h00ff

`endif

// ==== lut_ports_pkg.sv ====
package lut_ports_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] sel;
    logic [15:0] wdata;
  } host_req_type;

  typedef struct packed {
    logic [6:0] eta;
    logic [4:0] unit_a;
    logic [4:0] unit_b;
  } eta_unused_type;

  typedef struct packed {
    logic [6:0] st1;
    logic [6:0] st2;
    logic [6:0] st3;
    logic [6:0] st4;
  } station_eta_type;

  typedef enum logic [2:0] {
    S_RUN     = 3'b001,
    S_STOPPED = 3'b010,
    S_HELD    = 3'b100
  } trig_state_type;

endpackage
